// ---- hdl/psp_pkg.sv ----
/*
 * shared constants and types for the primary switch protection control block.
 * assumes a 40 MHz internal timebase clock and comparator flags already
 * synchronised to that clock.
 */
package psp_pkg;
    // timebase
    localparam int CLK_MHZ = 40;
    localparam int CLK_NS = 25;
    // times in their own units
    localparam int EARLY_LIMIT_WINDOW_NS = 500;
    localparam int SHORT_WINDOW_NS = 200;
    localparam int SOA_SKIP_US = 25;
    localparam int FORCED_OFF_US = 30;
    localparam int LINE_SENSE_OFF_US = 50;
    localparam int RESTART_ON_TIME_MS = 82;
    localparam int OVERLOAD_RATE_KHZ = 110;
    localparam int RESTART_OFF_TIME_MS = 1500;
    localparam int SHORT_RESTART_OFF_TIME_MS = 2000;
    localparam int REQUEST_LOSS_TIMEOUT_MS = 1000;
    localparam int LINE_UNDERVOLTAGE_TIMER_MS = 35;
    localparam int JITTER_PERIOD_US = 1000;
    localparam int RAMP_SPAN_US = 200;
    // cycle counts, every division rounded down
    localparam int EARLY_LIMIT_CYC = EARLY_LIMIT_WINDOW_NS / CLK_NS;
    localparam int SHORT_WINDOW_CYC = SHORT_WINDOW_NS / CLK_NS;
    localparam int SOA_SKIP_CYC = SOA_SKIP_US * CLK_MHZ;
    localparam int FORCED_OFF_CYC = FORCED_OFF_US * CLK_MHZ;
    localparam int LINE_SENSE_OFF_CYC = LINE_SENSE_OFF_US * CLK_MHZ;
    localparam int OVERLOAD_PERIOD_CYC = (CLK_MHZ * 1000) / OVERLOAD_RATE_KHZ;
    localparam int JITTER_HALF_CYC = JITTER_PERIOD_US * CLK_MHZ / 2;
    localparam int RAMP_STEP_CYC = RAMP_SPAN_US * CLK_MHZ / 70;
    localparam int RESTART_ON_TIME_CYC = RESTART_ON_TIME_MS * CLK_MHZ * 1000;
    localparam int RESTART_OFF_CYC = RESTART_OFF_TIME_MS * CLK_MHZ * 1000;
    localparam int SHORT_RESTART_OFF_CYC = SHORT_RESTART_OFF_TIME_MS * CLK_MHZ * 1000;
    localparam int REQUEST_LOSS_CYC = REQUEST_LOSS_TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int LINE_UV_CYC = LINE_UNDERVOLTAGE_TIMER_MS * CLK_MHZ * 1000;
    // current limit in percent
    localparam logic [6:0] LIMIT_FULL_PCT = 7'h64;
    localparam logic [6:0] LIMIT_JITTER_PCT = 7'h5F;
    localparam logic [6:0] LIMIT_FLOOR_PCT = 7'h1E;
    // timer width
    localparam int TW = 32;
    // main sequence
    typedef enum logic [2:0] {
        PSP_ST_CHARGE,
        PSP_ST_LINE_CHECK,
        PSP_ST_RUN,
        PSP_ST_RESTART_OFF,
        PSP_ST_LATCHED
    } psp_state_t;
    // on-cycle result reported by the cycle timer
    typedef enum logic [1:0] {
        PSP_HIT_NONE,
        PSP_HIT_NORMAL,
        PSP_HIT_EARLY,
        PSP_HIT_SHORT
    } psp_hit_t;
endpackage

// ---- hdl/psp_cycle_if.sv ----
/*
 * carries on-cycle timing results from the cycle timer to the controller.
 * assumes both ends share clk.
 */
`timescale 1ns/100ps
interface psp_cycle_if;
    logic gate_on; // switch conducting
    logic off_start; // pulse at turn-off
    psp_pkg::psp_hit_t hit; // pulse-valid limit classification
    logic [31:0] off_cycles; // cycles since last turn-off
    modport ctrl (output gate_on, input off_start, input hit, input off_cycles);
    modport tmr (input gate_on, output off_start, output hit, output off_cycles);
endinterface

// ---- hdl/psp_cycle_timer.sv ----
/*
 * times each on-cycle against the early windows and counts off-time.
 * assumes limit_hit is a synchronous comparator flag.
 */
`timescale 1ns/100ps
module psp_cycle_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic limit_hit,
    psp_cycle_if.tmr cy
);
    logic [15:0] on_cnt_reg; // cycles since turn-on
    logic gate_d_reg; // last gate level
    logic [31:0] off_cnt_reg; // cycles since turn-off, saturating
    logic [1:0] hit_reg; // classification pulse
    logic done_reg; // one classification per cycle

    //////////////////////////////////////////////////////////////////
    // on-time counter and limit classification
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            on_cnt_reg <= 16'h0000;
            hit_reg <= 2'h0;
            done_reg <= 1'b0;
        end else if (cy.gate_on) begin
            on_cnt_reg <= on_cnt_reg + 16'h0001;
            hit_reg <= 2'h0;
            if (limit_hit && !done_reg) begin
                done_reg <= 1'b1;
                if (on_cnt_reg < 16'(psp_pkg::SHORT_WINDOW_CYC)) begin
                    hit_reg <= 2'(psp_pkg::PSP_HIT_SHORT);
                end else if (on_cnt_reg < 16'(psp_pkg::EARLY_LIMIT_CYC)) begin
                    hit_reg <= 2'(psp_pkg::PSP_HIT_EARLY);
                end else begin
                    hit_reg <= 2'(psp_pkg::PSP_HIT_NORMAL);
                end
            end
        end else begin
            on_cnt_reg <= 16'h0000;
            hit_reg <= 2'h0;
            done_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // off-time counter, restarts at each turn-off
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gate_d_reg <= 1'b0;
            off_cnt_reg <= 32'h0000_0000;
        end else begin
            gate_d_reg <= cy.gate_on;
            if (cy.gate_on || (gate_d_reg && !cy.gate_on)) begin
                off_cnt_reg <= 32'h0000_0000;
            end else if (off_cnt_reg != 32'hFFFF_FFFF) begin
                off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
            end
        end
    end

    assign cy.hit = psp_pkg::psp_hit_t'(hit_reg);
    assign cy.off_start = gate_d_reg && !cy.gate_on;
    assign cy.off_cycles = off_cnt_reg;
endmodule

// ---- hdl/psp_limit_gen.sv ----
/*
 * forms the peak current limit percentage from off-time ramp and jitter.
 * assumes off_cycles counts cycles since the last turn-off.
 */
`timescale 1ns/100ps
module psp_limit_gen (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] off_cycles,
    output logic [6:0] limit_pct
);
    logic [31:0] jit_cnt_reg; // jitter half-period counter
    logic jit_lo_reg; // low jitter phase
    logic [6:0] limit_reg; // registered limit
    logic [31:0] drop; // percent lost to ramp
    logic [6:0] top_pct; // jitter-selected top of the ramp

    //////////////////////////////////////////////////////////////////
    // square jitter modulation of the top of the limit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            jit_cnt_reg <= 32'h0000_0000;
            jit_lo_reg <= 1'b0;
        end else if (jit_cnt_reg >= 32'(psp_pkg::JITTER_HALF_CYC - 1)) begin
            jit_cnt_reg <= 32'h0000_0000;
            jit_lo_reg <= !jit_lo_reg;
        end else begin
            jit_cnt_reg <= jit_cnt_reg + 32'h0000_0001;
        end
    end

    //////////////////////////////////////////////////////////////////
    // linear ramp down with off-time, clamped at the floor
    assign drop = off_cycles / 32'(psp_pkg::RAMP_STEP_CYC);
    // floor measured from the jittered top, so the low phase cannot dip under it
    assign top_pct = jit_lo_reg ? psp_pkg::LIMIT_JITTER_PCT : psp_pkg::LIMIT_FULL_PCT;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            limit_reg <= psp_pkg::LIMIT_FULL_PCT;
        end else if (drop >= 32'(top_pct - psp_pkg::LIMIT_FLOOR_PCT)) begin
            limit_reg <= psp_pkg::LIMIT_FLOOR_PCT;
        end else begin
            limit_reg <= top_pct - 7'(drop);
        end
    end
    assign limit_pct = limit_reg;
endmodule

// ---- hdl/psp_control.sv ----
/*
 * primary switch protection control top level.
 * assumes all comparator flags are synchronous to clk and that the
 * secondary cycle request arrives as a one-cycle pulse.
 */
`timescale 1ns/100ps
module psp_control #(
    parameter int RESTART_ON_CYC = psp_pkg::RESTART_ON_TIME_CYC,
    parameter int RESTART_OFF_CYC = psp_pkg::RESTART_OFF_CYC,
    parameter int SHORT_OFF_CYC = psp_pkg::SHORT_RESTART_OFF_CYC,
    parameter int REQ_LOSS_CYC = psp_pkg::REQUEST_LOSS_CYC,
    parameter int LINE_UV_CYC = psp_pkg::LINE_UV_CYC,
    parameter int SKIP_CYC = psp_pkg::SOA_SKIP_CYC,
    parameter int FORCED_CYC = psp_pkg::FORCED_OFF_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cycle_req,
    input wire logic limit_hit,
    input wire logic supply_uv,
    input wire logic supply_shunt_ok,
    input wire logic supply_charged,
    input wire logic supply_reset_low,
    input wire logic large_cap_detect,
    input wire logic supply_overcurrent_trip,
    input wire logic oc_latch_option,
    input wire logic thermal_latch_option,
    input wire logic thermal_trip_level,
    input wire logic thermal_cool,
    input wire logic line_above_brown_in,
    input wire logic line_below_brown_out,
    input wire logic line_over_voltage,
    input wire logic line_ac_reset,
    output logic gate_drive,
    output logic increased_limit,
    output logic [6:0] peak_current_limit,
    output logic line_sense_closed,
    output logic restart_active,
    output logic latched_off
);
    psp_cycle_if cy();
    psp_pkg::psp_state_t state_reg; // main sequence
    logic [31:0] off_tmr_reg; // restart off-time left
    logic [31:0] skip_tmr_reg; // soa or forced off left
    logic [31:0] req_loss_reg; // cycles since last request
    logic [31:0] req_gap_reg; // cycles since previous request
    logic [31:0] ovl_tmr_reg; // continuous overload duration
    logic [31:0] uv_tmr_reg; // brown-out duration
    logic uv_lock_reg; // supply undervoltage lockout
    logic thermal_hold_reg; // thermal disable
    logic early_prev_reg; // last hit was short, or an early hit not yet paired with a skip
    logic after_forced_reg; // first cycle after forced off
    logic brown_reg; // brown-out seen, waiting brown-in
    logic gate_reg; // gate drive
    logic inc_reg; // latched limit selection
    logic sense_reg; // line-sense switch
    logic [6:0] limit_pct; // ramp output
    logic fault_ar; // auto-restart request
    logic short_ar; // short-circuit restart request
    logic latch_req; // latch-off request
    logic clear_all; // supply reset or line undervoltage

    //////////////////////////////////////////////////////////////////
    // submodules
    psp_cycle_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .limit_hit(limit_hit),
        .cy(cy.tmr)
    );
    psp_limit_gen u_limit (
        .clk(clk),
        .rst_b(rst_b),
        .off_cycles(cy.off_cycles),
        .limit_pct(limit_pct)
    );
    assign cy.gate_on = gate_reg;

    //////////////////////////////////////////////////////////////////
    // clearing and fault decoding
    assign clear_all = supply_reset_low || line_below_brown_out;
    assign short_ar = after_forced_reg && (cy.hit == psp_pkg::PSP_HIT_SHORT);
    assign latch_req = supply_overcurrent_trip && oc_latch_option;
    assign fault_ar = (supply_overcurrent_trip && !oc_latch_option)
        || (ovl_tmr_reg >= 32'(RESTART_ON_CYC))
        || (req_loss_reg >= 32'(REQ_LOSS_CYC))
        || (uv_tmr_reg >= 32'(LINE_UV_CYC))
        || line_over_voltage;

    //////////////////////////////////////////////////////////////////
    // supply undervoltage lockout, held until shunt level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            uv_lock_reg <= 1'b1;
        end else if (supply_uv) begin
            uv_lock_reg <= 1'b1;
        end else if (supply_shunt_ok) begin
            uv_lock_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // thermal response, hysteretic or latching by option
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            thermal_hold_reg <= 1'b0;
        end else if (thermal_trip_level) begin
            thermal_hold_reg <= 1'b1;
        end else if (thermal_latch_option) begin
            if (clear_all) begin
                thermal_hold_reg <= 1'b0;
            end
        end else if (thermal_cool) begin
            thermal_hold_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // request timing: overload rate and request loss
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            req_gap_reg <= 32'h0000_0000;
            req_loss_reg <= 32'h0000_0000;
            ovl_tmr_reg <= 32'h0000_0000;
        end else if (state_reg != psp_pkg::PSP_ST_RUN) begin
            req_gap_reg <= 32'h0000_0000;
            req_loss_reg <= 32'h0000_0000;
            ovl_tmr_reg <= 32'h0000_0000;
        end else begin
            req_loss_reg <= cycle_req ? 32'h0000_0000 : req_loss_reg + 32'h0000_0001;
            req_gap_reg <= cycle_req ? 32'h0000_0000 : req_gap_reg + 32'h0000_0001;
            // overload held only while requests stay faster than the rate
            if (req_gap_reg > 32'(psp_pkg::OVERLOAD_PERIOD_CYC)) begin
                ovl_tmr_reg <= 32'h0000_0000;
            end else begin
                ovl_tmr_reg <= ovl_tmr_reg + 32'h0000_0001;
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // brown-out timer, held until brown-in returns
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            uv_tmr_reg <= 32'h0000_0000;
            brown_reg <= 1'b0;
        end else if (line_above_brown_in) begin
            uv_tmr_reg <= 32'h0000_0000;
            brown_reg <= 1'b0;
        end else if (line_below_brown_out || brown_reg) begin
            brown_reg <= 1'b1;
            uv_tmr_reg <= uv_tmr_reg + 32'h0000_0001;
        end
    end

    //////////////////////////////////////////////////////////////////
    // soa skip and rectifier-short forced off-time
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            skip_tmr_reg <= 32'h0000_0000;
            early_prev_reg <= 1'b0;
            after_forced_reg <= 1'b0;
        end else if (cy.hit == psp_pkg::PSP_HIT_SHORT) begin
            skip_tmr_reg <= 32'(FORCED_CYC);
            early_prev_reg <= 1'b1;
            after_forced_reg <= 1'b1;
        end else if (cy.hit == psp_pkg::PSP_HIT_EARLY) begin
            after_forced_reg <= 1'b0;
            early_prev_reg <= !early_prev_reg;
            if (early_prev_reg) begin
                skip_tmr_reg <= 32'(SKIP_CYC);
            end
        end else if (cy.hit == psp_pkg::PSP_HIT_NORMAL) begin
            after_forced_reg <= 1'b0;
            early_prev_reg <= 1'b0;
        end else if (skip_tmr_reg != 32'h0000_0000) begin
            skip_tmr_reg <= skip_tmr_reg - 32'h0000_0001;
        end
    end

    //////////////////////////////////////////////////////////////////
    // main sequence: start-up, run, restart and latch
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= psp_pkg::PSP_ST_CHARGE;
            off_tmr_reg <= 32'h0000_0000;
            inc_reg <= 1'b0;
        end else begin
            case (state_reg)
                psp_pkg::PSP_ST_CHARGE: begin
                    // selection caught once the supply has charged
                    if (supply_charged && !uv_lock_reg) begin
                        inc_reg <= large_cap_detect;
                        state_reg <= psp_pkg::PSP_ST_LINE_CHECK;
                    end
                end
                psp_pkg::PSP_ST_LINE_CHECK: begin
                    if (line_above_brown_in && !line_over_voltage) begin
                        state_reg <= psp_pkg::PSP_ST_RUN;
                    end
                end
                psp_pkg::PSP_ST_RUN: begin
                    if (latch_req) begin
                        state_reg <= psp_pkg::PSP_ST_LATCHED;
                    end else if (short_ar) begin
                        off_tmr_reg <= 32'(SHORT_OFF_CYC);
                        state_reg <= psp_pkg::PSP_ST_RESTART_OFF;
                    end else if (fault_ar) begin
                        off_tmr_reg <= 32'(RESTART_OFF_CYC);
                        state_reg <= psp_pkg::PSP_ST_RESTART_OFF;
                    end
                end
                psp_pkg::PSP_ST_RESTART_OFF: begin
                    if (line_ac_reset) begin
                        off_tmr_reg <= 32'h0000_0000;
                        state_reg <= psp_pkg::PSP_ST_LINE_CHECK;
                    end else if (off_tmr_reg > 32'h0000_0001) begin
                        off_tmr_reg <= off_tmr_reg - 32'h0000_0001;
                    end else begin
                        // line window rechecked, covers brown-in and ov recovery
                        state_reg <= psp_pkg::PSP_ST_LINE_CHECK;
                    end
                end
                psp_pkg::PSP_ST_LATCHED: begin
                    if (clear_all) begin
                        state_reg <= psp_pkg::PSP_ST_CHARGE;
                    end
                end
                default: begin
                    state_reg <= psp_pkg::PSP_ST_CHARGE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////
    // gate drive: on at request when allowed, off at limit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gate_reg <= 1'b0;
        end else if (uv_lock_reg || thermal_hold_reg
                || state_reg != psp_pkg::PSP_ST_RUN || fault_ar || latch_req) begin
            gate_reg <= 1'b0;
        end else if (gate_reg) begin
            gate_reg <= !limit_hit;
        end else if (cycle_req && skip_tmr_reg == 32'h0000_0000
                && cy.hit == psp_pkg::PSP_HIT_NONE) begin
            // a pending hit pulse would let a request slip in before the skip loads
            gate_reg <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////
    // line-sense switch opens after long off-time
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sense_reg <= 1'b1;
        end else if (gate_reg) begin
            sense_reg <= 1'b1;
        end else if (cy.off_cycles > 32'(psp_pkg::LINE_SENSE_OFF_CYC)) begin
            sense_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // registered status and limit outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            peak_current_limit <= psp_pkg::LIMIT_FULL_PCT;
            restart_active <= 1'b0;
            latched_off <= 1'b0;
        end else begin
            peak_current_limit <= limit_pct;
            restart_active <= state_reg == psp_pkg::PSP_ST_RESTART_OFF;
            latched_off <= state_reg == psp_pkg::PSP_ST_LATCHED;
        end
    end

    // all timers count clk; line-sense, overload-rate, jitter, ramp and early/short window times are package constants, the rest parameters
    assign gate_drive = gate_reg;
    assign increased_limit = inc_reg;
    assign line_sense_closed = sense_reg;
endmodule

// ---- test/psp_checker.sv ----
/* port-level assertions for the protection control top.
   assumes one clk domain and the bind at the foot of this file. */
`timescale 1ns/100ps
module psp_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cycle_req,
    input wire logic limit_hit,
    input wire logic supply_uv,
    input wire logic thermal_trip_level,
    input wire logic line_over_voltage,
    input wire logic line_ac_reset,
    input wire logic gate_drive,
    input wire logic [6:0] peak_current_limit,
    input wire logic line_sense_closed,
    input wire logic restart_active,
    input wire logic latched_off
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    //////////////////////////////////////////////////////////////////////////
    a_gate_on_req: assert property ($rose(gate_drive) |-> $past(cycle_req))
        else $error("gate rose without a request");
    a_uv_blocks_on: assert property (supply_uv ##1 supply_uv |=> !$rose(gate_drive))
        else $error("turn-on during supply undervoltage");
    a_limit_span: assert property (peak_current_limit >= 7'h1E && peak_current_limit <= 7'h64)
        else $error("limit outside thirty to hundred");
    a_limit_ends_on: assert property (gate_drive && limit_hit |=> !gate_drive)
        else $error("gate held past the limit");
    a_restart_gate_off: assert property (restart_active |-> !gate_drive)
        else $error("gate on during restart off");
    a_latch_gate_off: assert property (latched_off |-> !gate_drive)
        else $error("gate on while latched");
    a_ac_reset_ends: assert property (restart_active && line_ac_reset |-> ##[1:2] !restart_active)
        else $error("restart survived line reset");
    a_ov_blocks_on: assert property (line_over_voltage [*3] |=> !$rose(gate_drive))
        else $error("turn-on during line overvoltage");
    a_hot_blocks_on: assert property (thermal_trip_level [*2] |=> !$rose(gate_drive))
        else $error("turn-on while over temperature");
    a_sense_reclose: assert property ($rose(gate_drive) |-> ##[0:1] line_sense_closed)
        else $error("line sense left open in a cycle");
endmodule
bind psp_control psp_checker u_chk (.*);

// ---- test/psp_secondary_model.sv ----
/* far-side stand-in: sends cycle requests and ends each on-cycle.
   assumes the bench pulses fire for one cycle per wanted request. */
`timescale 1ns/100ps
module psp_secondary_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fire,
    input wire logic [7:0] on_len, // on-cycles before the limit; under 8 is short, under 20 early
    input wire logic gate_drive,
    output logic cycle_req,
    output logic limit_hit
);
    logic [7:0] on_cnt; // cycles since turn-on
    // falling-edge driver: request one cycle after fire, limit after on_len
    always_ff @(negedge clk) begin
        if (!rst_b) begin
            cycle_req <= 1'b0;
            limit_hit <= 1'b0;
            on_cnt <= 8'h00;
        end else begin
            cycle_req <= fire;
            limit_hit <= gate_drive && (on_cnt >= on_len);
            on_cnt <= gate_drive ? on_cnt + 8'h01 : 8'h00;
        end
    end
endmodule

// ---- test/psp_control_tb_top.sv ----
/* self-checking bench for the protection control.
   assumes shortened timer parameters; inputs move on the falling edge. */
`timescale 1ns/100ps
module psp_control_tb_top;
    logic clk, rst_b, fire, cycle_req, limit_hit, supply_uv, supply_shunt_ok;
    logic supply_charged, supply_reset_low, large_cap_detect, supply_overcurrent_trip;
    logic oc_latch_option, thermal_latch_option, thermal_trip_level, thermal_cool;
    logic line_above_brown_in, line_below_brown_out, line_over_voltage, line_ac_reset;
    logic gate_drive, increased_limit, line_sense_closed, restart_active, latched_off;
    logic [6:0] peak_current_limit;
    logic [7:0] on_len;
    int err_total, tests_run, cyc;
    // short timers keep the run near twenty-one thousand cycles
    psp_control #(.RESTART_ON_CYC(3000), .RESTART_OFF_CYC(300), .SHORT_OFF_CYC(400),
        .REQ_LOSS_CYC(10000), .LINE_UV_CYC(100), .SKIP_CYC(1000), .FORCED_CYC(1200)) DUT (.*);
    psp_secondary_model u_sec (.*);
    //////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 25000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one request; gate looked at two falling edges after it is taken
    task automatic cycle(input logic exp);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(2);
        chk({6'h00, gate_drive}, {6'h00, exp});
        tick(30);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, fire, supply_uv, supply_shunt_ok, supply_charged, supply_reset_low} = 6'h00;
        {supply_overcurrent_trip, oc_latch_option, thermal_latch_option} = 3'h0;
        {thermal_trip_level, thermal_cool, line_below_brown_out} = 3'h0;
        {line_over_voltage, line_ac_reset} = 2'h0;
        large_cap_detect = 1'b1; // large capacitor fitted
        on_len = 8'h17; // normal hit, past the early window
        line_above_brown_in = 1'b1;
        tick(16);
        rst_b = 1'b1;
        tick(1);
        chk({2'h0, gate_drive, increased_limit, line_sense_closed, restart_active,
            latched_off}, 7'h04);
        chk(peak_current_limit, 7'h64);
        supply_charged = 1'b1;
        tick(4);
        cycle(1'b0);
        supply_shunt_ok = 1'b1;
        tick(4);
        cycle(1'b1);
        chk({6'h00, increased_limit}, 7'h01);
        $display("test start-up done");
        supply_uv = 1'b1;
        supply_shunt_ok = 1'b0;
        tick(3);
        supply_uv = 1'b0;
        cycle(1'b0);
        supply_shunt_ok = 1'b1;
        tick(4);
        cycle(1'b1);
        $display("test undervoltage done");
        thermal_trip_level = 1'b1;
        tick(3);
        thermal_trip_level = 1'b0;
        cycle(1'b0);
        thermal_cool = 1'b1;
        tick(2);
        cycle(1'b1);
        thermal_cool = 1'b0;
        $display("test thermal done");
        tick(9000);
        chk({6'h00, line_sense_closed}, 7'h00);
        chk(peak_current_limit, 7'h1E);
        tick(1100);
        chk({6'h00, restart_active}, 7'h01);
        line_ac_reset = 1'b1;
        tick(3);
        chk({6'h00, restart_active}, 7'h00);
        line_ac_reset = 1'b0;
        tick(5);
        cycle(1'b1);
        chk({6'h00, line_sense_closed}, 7'h01);
        $display("test idle and line reset done");
        line_over_voltage = 1'b1;
        tick(5);
        chk({6'h00, restart_active}, 7'h01);
        cycle(1'b0);
        line_over_voltage = 1'b0;
        tick(320);
        cycle(1'b1);
        $display("test overvoltage done");
        oc_latch_option = 1'b1;
        supply_overcurrent_trip = 1'b1;
        tick(4);
        chk({6'h00, latched_off}, 7'h01);
        supply_overcurrent_trip = 1'b0;
        cycle(1'b0);
        supply_reset_low = 1'b1;
        tick(3);
        chk({6'h00, latched_off}, 7'h00);
        supply_reset_low = 1'b0;
        $display("test latch-off done");
        repeat (90) cycle(1'b1);
        tick(60);
        chk({6'h00, restart_active}, 7'h01);
        $display("test overload done");
        thermal_latch_option = 1'b1;
        thermal_trip_level = 1'b1;
        tick(300);
        thermal_trip_level = 1'b0;
        thermal_cool = 1'b1;
        tick(4);
        cycle(1'b0);
        thermal_cool = 1'b0;
        // brown-out also clears the thermal latch
        line_above_brown_in = 1'b0;
        line_below_brown_out = 1'b1;
        tick(110);
        chk({6'h00, restart_active}, 7'h01);
        line_below_brown_out = 1'b0;
        tick(400);
        cycle(1'b0);
        line_above_brown_in = 1'b1;
        tick(2);
        cycle(1'b1);
        $display("test thermal latch and brown-out done");
        on_len = 8'h0A;
        cycle(1'b1);
        cycle(1'b1);
        cycle(1'b0);
        tick(1000);
        cycle(1'b1);
        on_len = 8'h03;
        cycle(1'b1);
        cycle(1'b0);
        tick(1200);
        cycle(1'b1);
        on_len = 8'h17;
        tick(320);
        chk({6'h00, restart_active}, 7'h01);
        tick(60);
        chk({6'h00, restart_active}, 7'h00);
        $display("test soa and short done");
        // jitter low phase starts twenty thousand cycles after reset
        tick(3000);
        cycle(1'b1);
        chk(peak_current_limit, 7'h5F);
        rst_b = 1'b0;
        large_cap_detect = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(4);
        chk({6'h00, increased_limit}, 7'h00);
        cycle(1'b1);
        $display("test jitter and second reset done");
        tally_and_finish();
    end
endmodule
